/* File: rtl/ast_pkg.sv */
package ast_pkg;

	// strobe source selection
	typedef enum logic [1:0] {
		AST_SRC_COUNTER  = 2'h0,
		AST_SRC_DIVIDER  = 2'h1,
		AST_SRC_SOFTWARE = 2'h2,
		AST_SRC_EXTERNAL = 2'h3
	} ast_src_t;

	// external terminal group selection
	typedef enum logic [1:0] {
		AST_EXT_PIO  = 2'h0,
		AST_EXT_SYNC = 2'h1,
		AST_EXT_STAR = 2'h2
	} ast_ext_t;

	localparam int AST_PIO_W   = 6;
	localparam int AST_SYNC_W  = 8;
	localparam int AST_SEL_W   = 3;
	localparam int AST_CNT_W   = 24;
	localparam int AST_DIV_W   = 16;
	localparam int AST_CHN_W   = 6;
	localparam int AST_DLY_W   = 16;
	localparam int AST_REG_W   = 32;
	localparam int AST_ADDR_W  = 4;

	// register offsets (word addresses on the plain port)
	localparam logic [3:0] AST_R_CTRL   = 4'h0;
	localparam logic [3:0] AST_R_CMD    = 4'h1;
	localparam logic [3:0] AST_R_DIV    = 4'h2;
	localparam logic [3:0] AST_R_PRE    = 4'h3;
	localparam logic [3:0] AST_R_POST   = 4'h4;
	localparam logic [3:0] AST_R_CHAN   = 4'h5;
	localparam logic [3:0] AST_R_DELAY  = 4'h6;
	localparam logic [3:0] AST_R_STATUS = 4'h7;
	localparam logic [3:0] AST_R_COUNT  = 4'h8;

	// control field positions
	localparam int AST_C_SRC     = 0;
	localparam int AST_C_EXT     = 2;
	localparam int AST_C_SEL     = 4;
	localparam int AST_C_FALL    = 7;
	localparam int AST_C_PRETRIG = 8;
	localparam int AST_C_SWSTART = 9;
	localparam int AST_C_REFFALL = 10;
	localparam int AST_C_STFALL  = 11;

	// command bits
	localparam int AST_K_ARM    = 0;
	localparam int AST_K_START  = 1;
	localparam int AST_K_SAMPLE = 2;
	localparam int AST_K_STOP   = 3;

	// reset values; start-to-first-strobe delay defaults to two ticks
	localparam logic [AST_REG_W-1:0] AST_CTRL_RST = 32'h0000_0001;
	localparam logic [AST_DIV_W-1:0] AST_DIV_RST  = 16'h0001;
	localparam logic [AST_DLY_W-1:0] AST_DLY_RST  = 16'h0002;
	localparam logic [AST_CHN_W-1:0] AST_CHN_RST  = 6'h01;

	// acquisition phases
	typedef enum logic [2:0] {
		AST_IDLE,
		AST_ARMED,
		AST_PRE,
		AST_WAITREF,
		AST_POST,
		AST_DONE
	} ast_state_t;

	// raw strobe inputs from the terminals
	typedef struct packed {
		logic [AST_PIO_W-1:0]  pio;
		logic [AST_SYNC_W-1:0] sync;
		logic                  star;
		logic                  counter_out;
	} ast_terms_t;

endpackage

/* File: rtl/ast_divider.sv */
`timescale 1ns/1ps

// programmable divider of the sample timebase with a start delay
module ast_divider
	import ast_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 run,
	input  wire logic                 tick,
	input  wire logic [AST_DIV_W-1:0] divisor,
	input  wire logic [AST_DLY_W-1:0] delay,
	output logic                      strobe
);

	logic [AST_DLY_W-1:0] dly_q;
	logic [AST_DIV_W-1:0] cnt_q;
	logic                 first_q;
	logic                 strobe_q;
	wire                  dly_hit;
	wire                  div_hit;

	// first strobe waits for the delay, later ones for the divisor
	assign dly_hit = first_q && (dly_q <= 16'h0001);
	assign div_hit = !first_q && (cnt_q <= 16'h0001);
	assign strobe  = strobe_q;

	always_ff @(posedge clk) begin
		if (reset || !run) begin
			dly_q    <= delay;
			cnt_q    <= divisor;
			first_q  <= 1'b1;
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= tick && (dly_hit || div_hit);
			if (tick) begin
				if (dly_hit || div_hit) begin
					first_q <= 1'b0;
					cnt_q   <= divisor;
				end else if (first_q) begin
					dly_q <= dly_q - 16'h0001;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end
	end

	a_first_delay: assert property (@(posedge clk) disable iff (reset)
		$rose(run) |-> !strobe)
		else $error("strobe issued at start before delay");

endmodule

/* File: rtl/ast_engine.sv */
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - each accepted strobe samples every configured channel exactly once
// - configuration picks rising or falling edge for counter and external strobes
// - internal strobe is counter output, divided timebase, or software pulse
// - programmable counter divides the sample timebase
// - external strobe from terminals 0-5, sync lines 0-7, or star line
// - posttrigger mode loads post count, decrements per strobe, ends at zero
// - pretrigger mode loads pre count at start, decrements to zero
// - after pre count hits zero, reload with post count
// - reference events before pretrigger samples complete are ignored
// - after accepted reference, count posttrigger samples then stop
// - software start emits a pulse on the start event line
// - strobes are ignored while no acquisition runs
// - further strobes ignored until all conversions of a sample arrive
// - divided timebase strobe start delay is configurable, default two ticks
module ast_engine
	import ast_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [AST_ADDR_W-1:0] reg_addr,
	input  wire logic [AST_REG_W-1:0]  reg_wdata,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output logic      [AST_REG_W-1:0]  reg_rdata,
	input  wire ast_terms_t            terms,
	input  wire logic                  sample_timebase,
	input  wire logic                  acq_start_event,
	input  wire logic                  acq_reference_event,
	input  wire logic                  conversion_strobe,
	output logic                       acq_start_out,
	output logic                       acq_sample_strobe,
	output logic                       acq_done
);

	logic [AST_REG_W-1:0] ctrl_q;
	logic [AST_DIV_W-1:0] div_q;
	logic [AST_CNT_W-1:0] pre_q;
	logic [AST_CNT_W-1:0] post_q;
	logic [AST_CHN_W-1:0] chan_q;
	logic [AST_DLY_W-1:0] delay_q;
	logic [AST_REG_W-1:0] rdata_q;
	ast_state_t           state_q;
	ast_state_t           state_d;
	logic [AST_CNT_W-1:0] count_q;
	logic [AST_CNT_W-1:0] count_d;
	logic [AST_CHN_W-1:0] conv_q;
	logic                 busy_q;
	logic                 raw_q;
	logic                 tb_q;
	logic                 st_q;
	logic                 ref_q;
	logic                 start_out_q;
	logic                 strobe_q;
	logic                 done_q;
	logic                 pre_done_q;

	wire                  wr_ctrl;
	wire                  wr_cmd;
	wire                  cmd_arm;
	wire                  cmd_start;
	wire                  cmd_sample;
	wire                  cmd_stop;
	ast_src_t             src_sel;
	ast_ext_t             ext_sel;
	wire [AST_SEL_W-1:0]  term_sel;
	wire                  edge_fall;
	wire                  pretrig;
	wire                  sw_start;
	wire                  ext_raw;
	wire                  int_raw;
	wire                  raw_level;
	wire                  strobe_edge;
	wire                  div_strobe;
	wire                  running;
	wire                  accept;
	wire                  tb_tick;
	wire                  start_edge;
	wire                  ref_edge;
	wire                  start_go;
	wire                  ref_accept;
	wire                  conv_last;
	wire                  cnt_zero;
	wire [AST_REG_W-1:0]  rd_mux;

	// selects one bit of a terminal group; out-of-range reads as low
	function automatic logic pick_term(input logic [AST_SYNC_W-1:0] grp,
			input logic [AST_SEL_W-1:0] idx, input int width);
		pick_term = (int'(idx) < width) ? grp[idx] : 1'b0;
	endfunction

	// edge detector shared by strobe, start and reference inputs
	function automatic logic edge_of(input logic now, input logic prev,
			input logic fall);
		edge_of = fall ? (prev && !now) : (!prev && now);
	endfunction

	// register decode
	assign wr_ctrl    = reg_write && (reg_addr == AST_R_CTRL);
	assign wr_cmd     = reg_write && (reg_addr == AST_R_CMD);
	assign cmd_arm    = wr_cmd && reg_wdata[AST_K_ARM];
	assign cmd_start  = wr_cmd && reg_wdata[AST_K_START];
	assign cmd_sample = wr_cmd && reg_wdata[AST_K_SAMPLE];
	assign cmd_stop   = wr_cmd && reg_wdata[AST_K_STOP];

	// control fields
	assign src_sel   = ast_src_t'(ctrl_q[AST_C_SRC +: 2]);
	assign ext_sel   = ast_ext_t'(ctrl_q[AST_C_EXT +: 2]);
	assign term_sel  = ctrl_q[AST_C_SEL +: AST_SEL_W];
	assign edge_fall = ctrl_q[AST_C_FALL];
	assign pretrig   = ctrl_q[AST_C_PRETRIG];
	assign sw_start  = ctrl_q[AST_C_SWSTART];

	assign ext_raw = (ext_sel == AST_EXT_PIO)
			? pick_term({2'h0, terms.pio}, term_sel, AST_PIO_W)
		: (ext_sel == AST_EXT_SYNC)
			? pick_term(terms.sync, term_sel, AST_SYNC_W)
		: (ext_sel == AST_EXT_STAR) ? terms.star : 1'b0;

	assign int_raw = (src_sel == AST_SRC_COUNTER) ? terms.counter_out
		: (src_sel == AST_SRC_DIVIDER) ? div_strobe
		: (src_sel == AST_SRC_SOFTWARE) ? cmd_sample : 1'b0;

	assign raw_level = (src_sel == AST_SRC_EXTERNAL) ? ext_raw : int_raw;

	// edge polarity; software and divider pulses are always rising
	assign strobe_edge = ((src_sel == AST_SRC_DIVIDER)
			|| (src_sel == AST_SRC_SOFTWARE))
		? edge_of(raw_level, raw_q, 1'b0)
		: edge_of(raw_level, raw_q, edge_fall);

	assign tb_tick    = edge_of(sample_timebase, tb_q, 1'b0);
	assign start_edge = edge_of(acq_start_event, st_q,
		ctrl_q[AST_C_STFALL]);
	assign ref_edge   = edge_of(acq_reference_event, ref_q,
		ctrl_q[AST_C_REFFALL]);
	assign start_go   = (state_q == AST_ARMED)
		&& (sw_start ? cmd_start : start_edge);

	assign running = (state_q == AST_PRE) || (state_q == AST_WAITREF)
		|| (state_q == AST_POST);

	// no acceptance while conversions of a sample are pending
	assign accept    = running && !busy_q && strobe_edge;
	assign conv_last = busy_q && conversion_strobe
		&& (conv_q == AST_CHN_W'(1));
	assign cnt_zero  = (count_q == '0);

	// reference accepted only once pretrigger samples are complete
	assign ref_accept = (state_q == AST_WAITREF) && ref_edge;

	// timebase divider for the internal strobe
	ast_divider u_div (
		.clk     (clk),
		.reset   (reset),
		.run     (running && (src_sel == AST_SRC_DIVIDER)),
		.tick    (tb_tick),
		.divisor (div_q),
		.delay   (delay_q),
		.strobe  (div_strobe)
	);

	// acquisition sequencing and sample counter
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			AST_IDLE, AST_DONE: begin
				if (cmd_arm)
					state_d = AST_ARMED;
			end
			AST_ARMED: begin
				// load post count / load pre count at start
				if (start_go) begin
					state_d = pretrig ? AST_PRE : AST_POST;
					count_d = pretrig ? pre_q : post_q;
				end
			end
			AST_PRE: begin
				if (accept)
					count_d = count_q - AST_CNT_W'(1);
				if (cnt_zero || (accept && count_q == AST_CNT_W'(1))) begin
					state_d = AST_WAITREF;
					count_d = post_q;
				end
			end
			AST_WAITREF: begin
				if (ref_accept)
					state_d = AST_POST;
			end
			AST_POST: begin
				// decrement per accepted strobe until zero
				if (accept && !cnt_zero)
					count_d = count_q - AST_CNT_W'(1);
				if (cnt_zero || (accept && count_q == AST_CNT_W'(1)))
					state_d = AST_DONE;
			end
			default: state_d = AST_IDLE;
		endcase
		if (cmd_stop)
			state_d = AST_IDLE;
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q  <= AST_CTRL_RST;
			div_q   <= AST_DIV_RST;
			pre_q   <= '0;
			post_q  <= '0;
			chan_q  <= AST_CHN_RST;
			delay_q <= AST_DLY_RST;
		end else if (reg_write) begin
			if (wr_ctrl)
				ctrl_q <= reg_wdata;
			if (reg_addr == AST_R_DIV)
				div_q <= reg_wdata[AST_DIV_W-1:0];
			if (reg_addr == AST_R_PRE)
				pre_q <= reg_wdata[AST_CNT_W-1:0];
			if (reg_addr == AST_R_POST)
				post_q <= reg_wdata[AST_CNT_W-1:0];
			if (reg_addr == AST_R_CHAN)
				chan_q <= reg_wdata[AST_CHN_W-1:0];
			if (reg_addr == AST_R_DELAY)
				delay_q <= reg_wdata[AST_DLY_W-1:0];
		end
	end

	// state, counter and edge history
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= AST_IDLE;
			count_q <= '0;
			raw_q   <= 1'b0;
			tb_q    <= 1'b0;
			st_q    <= 1'b0;
			ref_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
			raw_q   <= raw_level;
			tb_q    <= sample_timebase;
			st_q    <= acq_start_event;
			ref_q   <= acq_reference_event;
		end
	end

	// one conversion per configured channel per accepted sample
	always_ff @(posedge clk) begin
		if (reset || !running) begin
			busy_q <= 1'b0;
			conv_q <= '0;
		end else if (accept) begin
			busy_q <= (chan_q != '0);
			conv_q <= chan_q;
		end else if (busy_q && conversion_strobe) begin
			conv_q <= conv_q - AST_CHN_W'(1);
			busy_q <= !conv_last;
		end
	end

	// output pulses and flags
	always_ff @(posedge clk) begin
		if (reset) begin
			start_out_q <= 1'b0;
			strobe_q    <= 1'b0;
			done_q      <= 1'b0;
			pre_done_q  <= 1'b0;
		end else begin
			start_out_q <= start_go && sw_start;
			strobe_q    <= accept;
			pre_done_q  <= (state_q == AST_WAITREF);
			if (state_d == AST_DONE)
				done_q <= 1'b1;
			else if (cmd_arm)
				done_q <= 1'b0;
		end
	end

	// read mux; unmapped offsets read zero
	assign rd_mux = (reg_addr == AST_R_CTRL)   ? ctrl_q
		: (reg_addr == AST_R_DIV)    ? {16'h0000, div_q}
		: (reg_addr == AST_R_PRE)    ? {8'h00, pre_q}
		: (reg_addr == AST_R_POST)   ? {8'h00, post_q}
		: (reg_addr == AST_R_CHAN)   ? {26'h0, chan_q}
		: (reg_addr == AST_R_DELAY)  ? {16'h0000, delay_q}
		: (reg_addr == AST_R_STATUS) ? {26'h0, busy_q, pre_done_q,
			done_q, 3'(state_q)}
		: (reg_addr == AST_R_COUNT)  ? {8'h00, count_q}
		: 32'h0000_0000;

	// read data held only for the cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset)
			rdata_q <= '0;
		else
			rdata_q <= reg_read ? rd_mux : 32'h0000_0000;
	end

	assign reg_rdata         = rdata_q;
	assign acq_start_out     = start_out_q;
	assign acq_sample_strobe = strobe_q;
	assign acq_done          = done_q;

	a_idle_ignore: assert property (@(posedge clk) disable iff (reset)
		!running |=> !acq_sample_strobe)
		else $error("strobe accepted while idle");

	a_busy_gate: assert property (@(posedge clk) disable iff (reset)
		busy_q |=> !acq_sample_strobe)
		else $error("strobe accepted during conversions");

	a_count_dec: assert property (@(posedge clk) disable iff (reset)
		(state_q == AST_POST && !accept && !cmd_stop) |=>
			count_q == $past(count_q))
		else $error("counter moved without accepted strobe");

	a_post_load: assert property (@(posedge clk) disable iff (reset)
		(start_go && !pretrig && !cmd_stop) |=> count_q == $past(post_q))
		else $error("post count not loaded");

	a_pre_load: assert property (@(posedge clk) disable iff (reset)
		(start_go && pretrig && !cmd_stop) |=> count_q == $past(pre_q))
		else $error("pre count not loaded");

	a_ref_ignore: assert property (@(posedge clk) disable iff (reset)
		(state_q == AST_PRE && !cmd_stop) |=> state_q != AST_POST)
		else $error("reference taken before pretrigger complete");

	a_sw_start: assert property (@(posedge clk) disable iff (reset)
		(start_go && sw_start) |=> acq_start_out)
		else $error("software start pulse missing");

	a_done_hold: assert property (@(posedge clk) disable iff (reset)
		(acq_done && !cmd_arm) |=> acq_done)
		else $error("done dropped before arm");

	c_post_done: cover property (@(posedge clk) state_q == AST_POST
		##1 state_q == AST_DONE);
	c_ref_taken: cover property (@(posedge clk) ref_accept);
	c_sample: cover property (@(posedge clk) accept ##[1:20] conv_last);

endmodule

/* File: verif/ast_far_side.sv */
`timescale 1ns/1ps

// timebase source and converter, as seen from the far side
module ast_far_side (
	input  wire logic clk,
	input  wire logic sample_strobe,
	input  wire logic [31:0] n_conv,
	input  wire logic [31:0] gap,
	output logic             timebase,
	output logic             conv
);
	int tb_div;

	// free running timebase, one tick every eight clocks
	// one process per signal keeps each with a single driver
	initial begin
		timebase = 1'b0;
		tb_div = 0;
		forever begin
			@(posedge clk);
			tb_div <= tb_div + 1;
			timebase <= tb_div[2];
		end
	end

	// conversions spaced two clocks apart
	// gap lets a scenario keep the engine busy on purpose
	initial begin
		conv = 1'b0;
		forever begin
			@(posedge clk);
			if (sample_strobe === 1'b1) begin
				repeat (gap) @(posedge clk);
				for (int i = 0; i < n_conv; i++) begin
					conv <= 1'b1;
					@(posedge clk);
					conv <= 1'b0;
					@(posedge clk);
				end
			end
		end
	end
endmodule

/* File: verif/acq_sample_timing_engine_tb_top.sv */
`timescale 1ns/1ps

module acq_sample_timing_engine_tb_top
	import ast_pkg::*;
;
	logic        clk;
	logic        reset;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [31:0] reg_rdata;
	ast_terms_t  terms;
	logic        timebase;
	logic        st_ev;
	logic        ref_ev;
	logic        conv;
	logic        start_out;
	logic        smp;
	logic        done;
	int          n_conv;
	int          gap;
	int          n_smp;
	int          n_so;
	int          err_total;
	int          n_compared;
	logic [31:0] d;

	ast_engine DUT (
		.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .terms(terms),
		.sample_timebase(timebase), .acq_start_event(st_ev),
		.acq_reference_event(ref_ev), .conversion_strobe(conv),
		.acq_start_out(start_out), .acq_sample_strobe(smp),
		.acq_done(done)
	);

	ast_far_side far (
		.clk(clk), .sample_strobe(smp), .n_conv(n_conv),
		.gap(gap), .timebase(timebase), .conv(conv)
	);

	always #20 clk = ~clk;

	// count output pulses as they stand
	always @(posedge clk) begin
		if (smp === 1'b1) n_smp++;
		if (start_out === 1'b1) n_so++;
	end

	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic rchk(input string nm, input logic [3:0] a,
		input logic [31:0] e);
		rd(a, d);
		chk(nm, e, d);
	endtask

	// level of the strobe source that the control word selects
	task automatic drv(input logic [31:0] c, input logic l);
		if (c[1:0] == 2'h0) terms.counter_out <= l;
		else if (c[3:2] == 2'h0) terms.pio[c[6:4]] <= l;
		else if (c[3:2] == 2'h1) terms.sync[c[6:4]] <= l;
		else terms.star <= l;
	endtask

	// one strobe on the selected source, then let conversions end
	task automatic hit(input logic [31:0] c);
		if (c[1:0] == 2'h2) wr(AST_R_CMD, 32'h4);
		else begin
			@(posedge clk);
			drv(c, ~c[7]);
			repeat (2) @(posedge clk);
			drv(c, c[7]);
		end
		repeat (12) @(posedge clk);
	endtask

	task automatic go(input logic [31:0] c, pre, post);
		wr(AST_R_CTRL, c);
		// idle level of the start input follows its edge polarity
		st_ev <= c[11];
		wr(AST_R_PRE, pre);
		wr(AST_R_POST, post);
		wr(AST_R_CMD, 32'h1);
		n_smp = 0;
		n_so = 0;
		if (c[9]) wr(AST_R_CMD, 32'h2);
		else begin
			@(posedge clk);
			st_ev <= ~c[11];
			repeat (2) @(posedge clk);
			st_ev <= c[11];
		end
		repeat (2) @(posedge clk);
	endtask

	task automatic state_is(input logic [2:0] e);
		rd(AST_R_STATUS, d);
		chk("state", e, d[2:0]);
	endtask

	task automatic t_reset;
		rchk("ctrl", AST_R_CTRL, 32'h1);
		rchk("div", AST_R_DIV, 32'h1);
		rchk("delay", AST_R_DELAY, 32'h2);
		rchk("chan", AST_R_CHAN, 32'h1);
		rchk("unmapped", 4'h9, 32'h0);
		$display("test reset done");
	endtask

	// counter source rising and every external group (terminals on both edges, sync rising, star falling), strobe before arm first
	task automatic t_ext;
		logic [31:0] tab [5];
		tab = '{32'h0, 32'h23, 32'hD3, 32'h77, 32'h8B};
		foreach (tab[i]) begin
			wr(AST_R_CTRL, tab[i]);
			drv(tab[i], tab[i][7]);
			n_smp = 0;
			hit(tab[i]);
			chk("idle strobe", 0, n_smp);
			go(tab[i], 0, 3);
			repeat (3) hit(tab[i]);
			chk("samples", 3, n_smp);
			chk("done", 1, done);
			rchk("count", AST_R_COUNT, 0);
		end
		$display("test external done");
	endtask

	task automatic t_busy;
		wr(AST_R_CHAN, 32'h2);
		n_conv = 2;
		gap = 30;
		go(32'h3, 0, 2);
		hit(32'h3);
		hit(32'h3);
		chk("busy strobe", 1, n_smp);
		repeat (40) @(posedge clk);
		rchk("count", AST_R_COUNT, 1);
		gap = 2;
		hit(32'h3);
		chk("done", 1, done);
		repeat (20) @(posedge clk);
		chk("done held", 1, done);
		wr(AST_R_CMD, 32'h1);
		@(posedge clk);
		#1 chk("done clear", 0, done);
		wr(AST_R_CMD, 32'h8);
		wr(AST_R_CHAN, 32'h1);
		n_conv = 1;
		$display("test busy done");
	endtask

	task automatic t_sw;
		go(32'h202, 0, 2);
		chk("start pulse", 1, n_so);
		repeat (2) hit(32'h202);
		chk("samples", 2, n_smp);
		chk("done", 1, done);
		$display("test software done");
	endtask

	// falling start and reference edges, so both inputs idle high
	task automatic t_pre;
		ref_ev <= 1'b1;
		go(32'hD03, 2, 2);
		chk("hw start pulse", 0, n_so);
		@(posedge clk);
		ref_ev <= 1'b0;
		repeat (2) @(posedge clk);
		ref_ev <= 1'b1;
		hit(32'hD03);
		state_is(3'h2);
		hit(32'hD03);
		state_is(3'h3);
		rchk("reload", AST_R_COUNT, 2);
		@(posedge clk);
		ref_ev <= 1'b0;
		repeat (2) @(posedge clk);
		ref_ev <= 1'b1;
		state_is(3'h4);
		repeat (2) hit(32'hD03);
		chk("samples", 4, n_smp);
		chk("done", 1, done);
		$display("test pretrigger done");
	endtask

	// default delay first, then a written one; ticks counted from start
	task automatic t_div;
		int tk;
		logic pv;
		wr(AST_R_DIV, 32'h2);
		st_ev <= 1'b0;
		wr(AST_R_CTRL, 32'h1);
		wr(AST_R_POST, 32'h3);
		for (int r = 2; r <= 3; r++) begin
			if (r == 3) wr(AST_R_DELAY, 32'h3);
			wr(AST_R_CMD, 32'h1);
			n_smp = 0;
			tk = 0;
			@(posedge clk);
			st_ev <= 1'b1;
			// start is taken here; the divider counts ticks from the next edge
			@(posedge clk);
			st_ev <= 1'b0;
			pv = timebase;
			for (int i = 0; i < 400 && n_smp == 0; i++) begin
				@(posedge clk);
				if (timebase && !pv) tk++;
				pv = timebase;
			end
			chk("delay ticks", r, tk);
			for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk);
			// one more edge so the last strobe is counted
			@(posedge clk);
			chk("samples", 3, n_smp);
			chk("done", 1, done);
		end
		$display("test divider done");
	endtask

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		terms = '0;
		st_ev = 1'b0;
		ref_ev = 1'b0;
		n_conv = 1;
		gap = 2;
		err_total = 0;
		n_compared = 0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_ext();
		t_busy();
		t_sw();
		t_pre();
		t_div();
		tally_and_finish();
	end

	// watchdog, well beyond the several hundred cycles the tests take
	initial begin
		#(40 * 20000);
		err_total++;
		tally_and_finish();
	end
endmodule
